// [include/split_desc_defines.vh]
`ifndef SPLIT_DESC_DEFINES_VH
`define SPLIT_DESC_DEFINES_VH

// Register word addresses
`define ADDR_DESC_LAST 4'h7
`define ADDR_CTRL 4'h8
`define ADDR_STATUS 4'h9
`define ADDR_INT_STATUS 4'hA
`define ADDR_INT_CLEAR 4'hB
`define ADDR_INT_ENABLE 4'hC

// Descriptor word indices
`define WORD_LEN 3'h0
`define WORD_ROUTE 3'h1
`define WORD_RESULT 3'h3

// Word 0 fields
`define LIMIT_MSB 28
`define LIMIT_LSB 18
`define COUNT_MSB 17
`define COUNT_LSB 3
`define ACTIVE_BIT 0

// Word 1 fields
`define SPEED_MSB 17
`define SPEED_LSB 16
`define SPLIT_BIT 14

// Speed codes for bulk and control splits
`define SPEED_LOW 2'h2
`define SPEED_FULL 2'h0

// Isochronous total byte count ceiling
`define ISO_MAX_BYTES 15'h0400

// Control register fields
`define CTRL_ENABLE_BIT 0
`define CTRL_ISO_BIT 1

// Interrupt bits
`define INT_DONE_BIT 0
`define INT_ERROR_BIT 1

// Reset values
`define CTRL_RESET 2'h0
`define INT_RESET 2'h0
`define WORD_RESET 32'h0000_0000

`endif

// [hw/split_transfer_descriptor.v]
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "split_desc_defines.vh"

// Behaviour
// - Each packet handed out is never longer than the 11-bit per-packet limit in bits 28 to 18.
// - The 15-bit total in bits 17 to 3 is the payload size moved for the whole descriptor.
// - The active flag in bit 0 is cleared when the descriptor completes or on a fatal error.
// - For bulk and control splits speed code 1,0 means low speed and 0,0 means full speed.
// - Isochronous splits are selected by control bit 1 and use the same eight-word descriptor layout.
// - An isochronous split total above one kilobyte is refused as a fatal error.
// - Outside iso mode, split bit zero runs a plain high-speed transaction, one runs a split transaction.
module split_transfer_descriptor #(
  parameter LIMIT_W = 11,
  parameter COUNT_W = 15
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Register port
  input wire [3:0] addr_in,
  input wire [31:0] wr_data_in,
  input wire wr_en_in,
  input wire rd_en_in,
  output reg [31:0] rd_data_out,
  // Packet engine side
  output reg pkt_req_out,
  output reg [LIMIT_W-1:0] pkt_len_out,
  output reg split_out,
  output reg low_speed_out,
  input wire pkt_done_in,
  input wire [LIMIT_W-1:0] pkt_bytes_in,
  input wire pkt_err_in,
  // Status
  output reg busy_out,
  output reg irq_out
);

  localparam S_IDLE = 4'b0001;
  localparam S_ISSUE = 4'b0010;
  localparam S_WAIT = 4'b0100;
  localparam S_FINISH = 4'b1000;

  reg [31:0] desc [0:7];
  reg [3:0] state;
  reg [1:0] ctrl;
  reg [1:0] int_status;
  reg [1:0] int_enable;
  reg [LIMIT_W-1:0] limit;
  reg [COUNT_W-1:0] remain;
  reg [COUNT_W-1:0] moved;
  reg fail;
  reg [1:0] next_events;
  reg [3:0] next_state;
  reg [LIMIT_W-1:0] got;
  integer i;

  wire desc_wr = wr_en_in && (addr_in <= `ADDR_DESC_LAST);
  wire [31:0] word0 = desc[`WORD_LEN];
  wire [31:0] word1 = desc[`WORD_ROUTE];
  wire [LIMIT_W-1:0] field_limit = word0[`LIMIT_MSB:`LIMIT_LSB];
  wire [COUNT_W-1:0] field_count = word0[`COUNT_MSB:`COUNT_LSB];
  wire iso_mode = ctrl[`CTRL_ISO_BIT];

  // Smaller of the remaining bytes and the limit
  function [LIMIT_W-1:0] clip;
    input [COUNT_W-1:0] left;
    input [LIMIT_W-1:0] lim;
    begin
      if (left < {{(COUNT_W-LIMIT_W){1'b0}}, lim}) begin
        clip = left[LIMIT_W-1:0];
      end else begin
        clip = lim;
      end
    end
  endfunction

  // Next state and events
  always @* begin
    next_state = state;
    next_events = 2'h0;
    got = pkt_bytes_in;
    if (pkt_bytes_in > pkt_len_out) begin
      got = pkt_len_out;
    end
    case (state)
      S_IDLE: begin
        if (ctrl[`CTRL_ENABLE_BIT] && word0[`ACTIVE_BIT] && !desc_wr) begin
          if (iso_mode && (field_count > `ISO_MAX_BYTES)) begin
            next_state = S_FINISH;
          end else if (field_count == {COUNT_W{1'b0}}) begin
            next_state = S_FINISH;
          end else if (field_limit == {LIMIT_W{1'b0}}) begin
            next_state = S_FINISH;
          end else begin
            next_state = S_ISSUE;
          end
        end
      end
      S_ISSUE: begin
        next_state = S_WAIT;
      end
      S_WAIT: begin
        if (pkt_err_in) begin
          next_state = S_FINISH;
        end else if (pkt_done_in) begin
          // A short packet ends the transfer early
          if ((got < pkt_len_out) || (remain == {{(COUNT_W-LIMIT_W){1'b0}}, got})) begin
            next_state = S_FINISH;
          end else begin
            next_state = S_ISSUE;
          end
        end
      end
      S_FINISH: begin
        next_state = S_IDLE;
        if (fail) begin
          next_events[`INT_ERROR_BIT] = 1'b1;
        end else begin
          next_events[`INT_DONE_BIT] = 1'b1;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // Transfer engine
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= S_IDLE;
      limit <= {LIMIT_W{1'b0}};
      remain <= {COUNT_W{1'b0}};
      moved <= {COUNT_W{1'b0}};
      fail <= 1'b0;
      pkt_req_out <= 1'b0;
      pkt_len_out <= {LIMIT_W{1'b0}};
      split_out <= 1'b0;
      low_speed_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      state <= next_state;
      pkt_req_out <= 1'b0;
      busy_out <= (next_state != S_IDLE);
      if (state == S_IDLE && next_state != S_IDLE) begin
        limit <= field_limit;
        remain <= field_count;
        moved <= {COUNT_W{1'b0}};
        fail <= (next_state == S_FINISH) && (field_count != {COUNT_W{1'b0}});
        // iso always via the translator at full speed
        if (iso_mode) begin
          split_out <= 1'b1;
          low_speed_out <= 1'b0;
        end else begin
          split_out <= word1[`SPLIT_BIT];
          low_speed_out <= word1[`SPLIT_BIT] &&
                           (word1[`SPEED_MSB:`SPEED_LSB] == `SPEED_LOW);
        end
      end
      if (state == S_ISSUE) begin
        pkt_req_out <= 1'b1;
        pkt_len_out <= clip(remain, limit);
      end
      if (state == S_WAIT && pkt_err_in) begin
        fail <= 1'b1;
      end else if (state == S_WAIT && pkt_done_in) begin
        remain <= remain - {{(COUNT_W-LIMIT_W){1'b0}}, got};
        moved <= moved + {{(COUNT_W-LIMIT_W){1'b0}}, got};
      end
    end
  end

  // Descriptor store; a software write in the finishing cycle wins
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (i = 0; i < 8; i = i + 1) begin
        desc[i] <= `WORD_RESET;
      end
    end else if (desc_wr) begin
      desc[addr_in[2:0]] <= wr_data_in;
    end else if (state == S_FINISH) begin
      desc[`WORD_LEN][`ACTIVE_BIT] <= 1'b0;
      if (iso_mode) begin
        desc[`WORD_RESULT][11:0] <= moved[11:0];
      end else begin
        desc[`WORD_RESULT][COUNT_W-1:0] <= moved;
      end
    end
  end

  // Control and interrupt registers
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl <= `CTRL_RESET;
      int_status <= `INT_RESET;
      int_enable <= `INT_RESET;
      irq_out <= 1'b0;
    end else begin
      if (wr_en_in && addr_in == `ADDR_CTRL) begin
        ctrl <= wr_data_in[1:0];
      end
      if (wr_en_in && addr_in == `ADDR_INT_ENABLE) begin
        int_enable <= wr_data_in[1:0];
      end
      // New events win over a clear in the same cycle
      if (wr_en_in && addr_in == `ADDR_INT_CLEAR) begin
        int_status <= (int_status & ~wr_data_in[1:0]) | next_events;
      end else begin
        int_status <= int_status | next_events;
      end
      irq_out <= |((int_status | next_events) & int_enable);
    end
  end

  // Read port, data one cycle after the strobe
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_data_out <= 32'h0000_0000;
    end else if (rd_en_in) begin
      if (addr_in <= `ADDR_DESC_LAST) begin
        rd_data_out <= desc[addr_in[2:0]];
      end else if (addr_in == `ADDR_CTRL) begin
        rd_data_out <= {30'h0000_0000, ctrl};
      end else if (addr_in == `ADDR_STATUS) begin
        rd_data_out <= {moved, 11'h000, fail, busy_out, state};
      end else if (addr_in == `ADDR_INT_STATUS) begin
        rd_data_out <= {30'h0000_0000, int_status};
      end else if (addr_in == `ADDR_INT_ENABLE) begin
        rd_data_out <= {30'h0000_0000, int_enable};
      end else begin
        rd_data_out <= 32'h0000_0000;
      end
    end else begin
      rd_data_out <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// [tb/split_desc_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "split_desc_defines.vh"
module split_desc_sva #(
  parameter LIMIT_W = 11
) (
  // Clock, reset and register port
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_en_in,
  // Engine side and status
  input wire logic pkt_req_out,
  input wire logic [LIMIT_W-1:0] pkt_len_out,
  input wire logic split_out,
  input wire logic low_speed_out,
  input wire logic busy_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_quiet;
    !pkt_req_out [*2];
  endsequence
  sequence s_req_end;
    pkt_req_out ##1 !pkt_req_out;
  endsequence
  property p_gap; pkt_req_out |=> s_quiet; endproperty
  a_gap: assert property (p_gap) else $error("request gap too short");
  property p_hold; s_req_end |-> $stable(pkt_len_out); endproperty
  a_hold: assert property (p_hold) else $error("length moved");
  property p_len; pkt_req_out |-> pkt_len_out != 11'h000; endproperty
  a_len: assert property (p_len) else $error("empty packet");
  property p_busy; pkt_req_out |-> busy_out; endproperty
  a_busy: assert property (p_busy) else $error("request while idle");
  property p_low; low_speed_out |-> split_out; endproperty
  a_low: assert property (p_low) else $error("low speed without split");
  property p_idle; !busy_out |-> !pkt_req_out; endproperty
  a_idle: assert property (p_idle) else $error("inactive work issued");
  // Route fixed for the whole descriptor
  property p_split; busy_out && $past(busy_out) |-> $stable({split_out, low_speed_out}); endproperty
  a_split: assert property (p_split) else $error("route changed");
  property p_mask;
    wr_en_in && addr_in == `ADDR_INT_ENABLE && wr_data_in[1:0] == 2'h0 |-> ##2 !irq_out;
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt high");
endmodule
bind split_transfer_descriptor split_desc_sva #(.LIMIT_W(LIMIT_W)) u_sva (.clk_in, .rst_n_in,
  .addr_in, .wr_data_in, .wr_en_in, .pkt_req_out, .pkt_len_out, .split_out, .low_speed_out,
  .busy_out, .irq_out);
`default_nettype wire

// [tb/pkt_engine_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pkt_engine_model (
  // Engine handshake
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic [10:0] len_in,
  input wire logic fail_in,
  input wire logic short_in,
  output logic done_out,
  output logic err_out,
  output logic [10:0] bytes_out
);
  int k = 0;
  initial begin
    {done_out, err_out, bytes_out} = 0;
    forever begin
      @(posedge clk_in);
      if (req_in === 1'b1) begin
        k++;
        // Reply delay varies so both prompt and slow answers occur
        repeat (k % 4) @(posedge clk_in);
        // never over length; short reply or fault only on command
        bytes_out <= short_in ? len_in - 11'h001 : len_in;
        done_out <= !fail_in;
        err_out <= fail_in;
        @(posedge clk_in);
        {done_out, err_out} <= 2'h0;
        bytes_out <= ~len_in;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/split_transfer_descriptor_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "split_desc_defines.vh"
module split_transfer_descriptor_tb;
  logic clk_in = 0, rst_n_in = 0, wr_en_in = 0, rd_en_in = 0, fail = 0, shrt = 0;
  logic [3:0] addr_in = 0;
  logic [31:0] wr_data_in = 0, lf = 32'h0000_8f28;
  wire [31:0] rd_data_out;
  wire [10:0] pkt_len_out, pkt_bytes_in;
  wire pkt_req_out, split_out, low_speed_out, pkt_done_in, pkt_err_in, busy_out, irq_out;
  int mismatches = 0, checks_done = 0, ien = 1;
  always #25 clk_in = ~clk_in;
  split_transfer_descriptor u_split_transfer_descriptor (.clk_in, .rst_n_in, .addr_in,
    .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out, .pkt_req_out, .pkt_len_out, .split_out,
    .low_speed_out, .pkt_done_in, .pkt_bytes_in, .pkt_err_in, .busy_out, .irq_out);
  pkt_engine_model u_pkt_engine_model (.clk_in, .req_in(pkt_req_out), .len_in(pkt_len_out),
    .fail_in(fail), .short_in(shrt), .done_out(pkt_done_in), .err_out(pkt_err_in),
    .bytes_out(pkt_bytes_in));
  function automatic logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic wrap_up;
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic ck(logic [31:0] g, logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1;
    @(posedge clk_in);
    wr_en_in <= 0;
  endtask
  task automatic rd(logic [3:0] a, logic [31:0] m, logic [31:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_en_in <= 1;
    @(posedge clk_in);
    rd_en_in <= 0;
    @(negedge clk_in);
    ck(rd_data_out & m, e);
  endtask
  task automatic run(int lim, int tot, int sp, int spd, int iso, int f);
    int n, mx, t, mv;
    logic ev;
    n = 0;
    mx = 0;
    fail <= f == 1;
    shrt <= f == 2;
    ev = lim == 0 || (iso && tot > 16'h0400) || f == 1;
    // A short reply ends the descriptor after its first packet
    mv = ev ? 0 : f == 2 ? (tot < lim ? tot : lim) - 1 : tot;
    wr(`ADDR_CTRL, {30'h0, iso[0], 1'b1});
    wr(1, (sp << 14) | (spd << 16));
    // active only with a descriptor ready
    wr(0, (lim << 18) | (tot << 3) | 1);
    for (t = 0; t < 3000 && (t < 3 || busy_out === 1'b1); t++) begin
      @(negedge clk_in);
      if (pkt_req_out === 1'b1) begin
        n++;
        if (pkt_len_out > mx) mx = pkt_len_out;
        ck(split_out, iso | sp);
        ck(low_speed_out, !iso && sp && spd == 2);
      end
    end
    if (t == 3000) begin
      mismatches++;
      wrap_up;
    end
    ck(n, f ? 1 : ev ? 0 : (tot + lim - 1) / lim);
    ck(mx, (ev && !f) ? 0 : (tot < lim ? tot : lim));
    rd(0, 32'hffff_ffff, (lim << 18) | (tot << 3));
    rd(`WORD_RESULT, 32'h0000_7fff, mv);
    rd(`ADDR_STATUS, 32'hffff_ffff, (mv << 17) | (ev ? 32 : 0) | 1);
    rd(`ADDR_INT_STATUS, 32'h0000_0003, ev ? 2 : 1);
    ck(irq_out, ien);
    wr(`ADDR_INT_CLEAR, 3);
    repeat (2) @(negedge clk_in);
    ck(irq_out, 0);
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1;
    rd(`ADDR_CTRL, 32'hffff_ffff, 0);
    rd(4'hE, 32'hffff_ffff, 0);
    wr(`ADDR_INT_ENABLE, 3);
    rd(`ADDR_INT_ENABLE, 32'hffff_ffff, 3);
    run(64, 100, 1, 2, 0, 0);
    run(8, 0, 0, 0, 0, 0);
    run(0, 40, 1, 0, 0, 0);
    run(64, 16'h0400, 0, 0, 1, 0);
    run(64, 16'h0401, 0, 0, 1, 0);
    run(16, 50, 1, 0, 0, 1);
    run(20, 90, 0, 0, 0, 2);
    repeat (6) begin
      lf = nx(lf);
      run(lf[5:0] + 1, lf[16:8], lf[20], lf[21] ? 2 : 0, 0, 0);
    end
    wr(0, 32'h0040_0050);
    repeat (4) @(negedge clk_in);
    ck(busy_out, 0);
    rd(0, 32'hffff_ffff, 32'h0040_0050);
    ien = 0;
    wr(`ADDR_INT_ENABLE, 0);
    run(32, 70, 0, 0, 0, 0);
    // Engine switched off must leave an active descriptor alone
    wr(`ADDR_CTRL, 0);
    wr(0, 32'h0040_0051);
    repeat (4) @(negedge clk_in);
    ck(busy_out, 0);
    rd(0, 32'hffff_ffff, 32'h0040_0051);
    wrap_up;
  end
endmodule
`default_nettype wire
